// ===== pwmgc_top.sv
// pwm generator control, duty select, time base and interrupt logic behind an axi4-lite slave
// Functional notes
// - fault event sets fault pending; enable written zero clears it
// - current-limit event sets its pending flag; enable zero clears it
// - trigger event with enable set raises request and pending; enable zero clears
// - independent time base takes period from phase value, else master period
// - master duty select takes duty from master duty, else own duty registers
// - dead-time field: 00 positive, 01 negative, 10 off, 11 reserved
// - center-aligned mode only acts with independent time base set
// - external reset bit lets current-limit source reset independent time base
// - immediate update applies duty at once, otherwise at period boundary
// - primary duty drives high only in independent mode, both outputs otherwise
// - duty near period start or end coarsens to three-count steps
// - primary duty is sixteen-bit read/write, resets to zero
// - module enable turns the time base and both outputs on or off
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`include "pwmgc_cfg.svh"
module pwmgc_top
	import pwmgc_pkg::*;
#(
	parameter logic [15:0] DEAD_CYCLES = 16'h0008,
	parameter logic [15:0] EDGE_CYCLES = 16'(`PWMGC_EDGE_CYC)
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic fault_event,
	input wire logic current_limit_event,
	input wire logic trigger_event,
	output logic high_output,
	output logic low_output,
	output logic generator_irq,
	output logic irq
);
	pwmgc_state_t s, n;

	// byte-lane merge for the 16-bit registers
	function automatic logic [15:0] wr16(input logic [15:0] old, input logic [15:0] d, input logic [1:0] st);
		wr16 = old;
		if (st[0]) begin
			wr16[7:0] = d[7:0];
		end
		if (st[1]) begin
			wr16[15:8] = d[15:8];
		end
	endfunction

	// coarse duty near the period edges, dropped to a multiple of three
	function automatic logic [15:0] coarsen(input logic [15:0] d, input logic [15:0] per, input logic [15:0] edge_c);
		coarsen = d;
		if ((d < edge_c) || ({1'b0, d} + {1'b0, edge_c} > {1'b0, per})) begin
			coarsen = d - (d % 16'(`PWMGC_COARSE_STEP));
		end
	endfunction

	logic do_wr;
	logic do_rd;
	logic hit;
	logic [15:0] wv;
	logic [15:0] per;
	logic center;
	logic boundary;
	logic ext_rst;
	logic cmp;
	logic settled;
	logic raw_h;
	logic raw_l;
	logic [15:0] dh;
	logic [15:0] dl;
	logic [15:0] src_h;
	logic [15:0] src_l;
	logic [15:0] rd;
	logic [3:0] ev;
	logic [3:0] rd_clr;
	logic flt_p;
	logic cl_p;
	logic trg_p;

	always_comb begin
		n = s;
		do_wr = 1'b0;
		do_rd = 1'b0;
		hit = 1'b1;
		wv = 16'h0000;
		rd = 16'h0000;
		rd_clr = 4'h0;
		// ----------------------------------------
		// axi4-lite write side
		// ----------------------------------------
		if (s_axi_awvalid && s.awready) begin
			n.aw_held = 1'b1;
			n.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wready) begin
			n.w_held = 1'b1;
			n.wdata = s_axi_wdata[15:0];
			n.wstrb = s_axi_wstrb[1:0];
		end
		if (s.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		// address and data may arrive in either order
		if (s.aw_held && s.w_held && !s.bvalid) begin
			do_wr = 1'b1;
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
		end
		// ----------------------------------------
		// register writes
		// ----------------------------------------
		if (do_wr) begin
			unique case (s.awaddr)
				`PWMGC_OFF_CTRL: begin
					wv = wr16(s.ctrl, s.wdata, s.wstrb);
					// pending bits keep their value unless a zero is written
					n.ctrl = (wv & `PWMGC_CTRL_WMASK) | (s.ctrl & ~(`PWMGC_CTRL_WMASK));
					n.ctrl[`PWMGC_B_FLT_PEND] = s.ctrl[`PWMGC_B_FLT_PEND] & wv[`PWMGC_B_FLT_PEND];
					n.ctrl[`PWMGC_B_CL_PEND] = s.ctrl[`PWMGC_B_CL_PEND] & wv[`PWMGC_B_CL_PEND];
					n.ctrl[`PWMGC_B_TRG_PEND] = s.ctrl[`PWMGC_B_TRG_PEND] & wv[`PWMGC_B_TRG_PEND];
				end
				`PWMGC_OFF_PDUTY: n.pduty = wr16(s.pduty, s.wdata, s.wstrb);
				`PWMGC_OFF_MODCTL: begin
					wv = wr16({s.mod_en, 13'h0000, s.omode}, s.wdata, s.wstrb);
					n.mod_en = wv[`PWMGC_B_MOD_EN];
					n.omode = wv[1:0];
				end
				`PWMGC_OFF_MPER: n.mper = wr16(s.mper, s.wdata, s.wstrb);
				`PWMGC_OFF_MDUTY: n.mduty = wr16(s.mduty, s.wdata, s.wstrb);
				`PWMGC_OFF_PHASE: n.phase = wr16(s.phase, s.wdata, s.wstrb);
				`PWMGC_OFF_SDUTY: n.sduty = wr16(s.sduty, s.wdata, s.wstrb);
				`PWMGC_OFF_IRQST: hit = 1'b1;
				`PWMGC_OFF_IRQMSK: begin
					wv = wr16({12'h000, s.mask}, s.wdata, s.wstrb);
					n.mask = wv[3:0];
				end
				default: hit = 1'b0;
			endcase
			n.bresp = hit ? `PWMGC_RESP_OKAY : `PWMGC_RESP_SLVERR;
		end
		// ----------------------------------------
		// axi4-lite read side
		// ----------------------------------------
		if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s.arready) begin
			do_rd = 1'b1;
			hit = 1'b1;
			unique case (s_axi_araddr)
				`PWMGC_OFF_CTRL: rd = s.ctrl;
				`PWMGC_OFF_PDUTY: rd = s.pduty;
				`PWMGC_OFF_MODCTL: rd = {s.mod_en, 13'h0000, s.omode};
				`PWMGC_OFF_MPER: rd = s.mper;
				`PWMGC_OFF_MDUTY: rd = s.mduty;
				`PWMGC_OFF_PHASE: rd = s.phase;
				`PWMGC_OFF_SDUTY: rd = s.sduty;
				`PWMGC_OFF_IRQST: begin
					rd = {12'h000, s.status};
					rd_clr = s.status; // reading the status clears what it showed
				end
				`PWMGC_OFF_IRQMSK: rd = {12'h000, s.mask};
				default: hit = 1'b0;
			endcase
			n.rvalid = 1'b1;
			n.rdata = {16'h0000, rd};
			n.rresp = hit ? `PWMGC_RESP_OKAY : `PWMGC_RESP_SLVERR;
		end
		// ----------------------------------------
		// time base
		// ----------------------------------------
		per = s.ctrl[`PWMGC_B_ITB] ? s.phase : s.mper;
		center = s.ctrl[`PWMGC_B_ITB] & s.ctrl[`PWMGC_B_CAM];
		ext_rst = s.ctrl[`PWMGC_B_EXTERNAL_RESET_CONTROL] & s.ctrl[`PWMGC_B_ITB] & current_limit_event;
		boundary = 1'b0;
		if (!s.mod_en) begin
			// disabled generator holds its counter at the start
			n.cnt = 16'h0000;
			n.dir_down = 1'b0;
		end else if (ext_rst) begin
			n.cnt = 16'h0000;
			n.dir_down = 1'b0;
			boundary = 1'b1;
		end else if (center) begin
			if (!s.dir_down) begin
				n.cnt = s.cnt + 16'h0001;
				n.dir_down = (s.cnt + 16'h0001 >= per);
			end else if (s.cnt <= 16'h0001) begin
				n.cnt = 16'h0000;
				n.dir_down = 1'b0;
				boundary = 1'b1;
			end else begin
				n.cnt = s.cnt - 16'h0001;
			end
		end else if (s.cnt >= per) begin
			n.cnt = 16'h0000;
			boundary = 1'b1;
		end else begin
			n.cnt = s.cnt + 16'h0001;
		end
		if (boundary) begin
			n.pp_sel = ~s.pp_sel;
		end
		// ----------------------------------------
		// duty source and update timing
		// ----------------------------------------
		src_h = s.ctrl[`PWMGC_B_MASTER_DUTY_SELECT] ? s.mduty : s.pduty;
		src_l = s.ctrl[`PWMGC_B_MASTER_DUTY_SELECT] ? s.mduty : s.sduty;
		// synchronised loads avoid a glitch pulse mid-period
		if (s.ctrl[`PWMGC_B_IUE] || boundary || !s.mod_en) begin
			n.act_h = src_h;
			n.act_l = src_l;
		end
		dh = coarsen(s.act_h, per, EDGE_CYCLES);
		dl = coarsen(s.act_l, per, EDGE_CYCLES);
		// ----------------------------------------
		// output shaping
		// ----------------------------------------
		cmp = s.cnt < dh;
		unique case (s.omode)
			`PWMGC_OM_CMP: begin
				raw_h = cmp;
				raw_l = ~cmp;
			end
			`PWMGC_OM_RED: begin
				raw_h = cmp;
				raw_l = cmp;
			end
			`PWMGC_OM_PP: begin
				raw_h = cmp & ~s.pp_sel;
				raw_l = cmp & s.pp_sel;
			end
			default: begin
				raw_h = cmp;
				raw_l = s.cnt < dl;
			end
		endcase
		// dead-time window restarts on each comparator edge
		n.cmp_prev = cmp;
		if (cmp != s.cmp_prev) begin
			n.dt_cnt = 16'h0000;
		end else if (s.dt_cnt < DEAD_CYCLES) begin
			n.dt_cnt = s.dt_cnt + 16'h0001;
		end
		settled = (s.dt_cnt >= DEAD_CYCLES) && (cmp == s.cmp_prev);
		unique case (s.ctrl[`PWMGC_B_DTC_HI:`PWMGC_B_DTC_LO])
			`PWMGC_DTC_POS: begin
				n.hi = raw_h & settled;
				n.lo = raw_l & settled;
			end
			`PWMGC_DTC_NEG: begin
				n.hi = raw_h | ~settled;
				n.lo = raw_l | ~settled;
			end
			default: begin
				// reserved code behaves as dead time off
				n.hi = raw_h;
				n.lo = raw_l;
			end
		endcase
		if (!s.mod_en) begin
			n.hi = 1'b0;
			n.lo = 1'b0;
		end
		// ----------------------------------------
		// pending flags and interrupts
		// ----------------------------------------
		// an enable at zero holds its flag clear; an event beats a written zero
		flt_p = n.ctrl[`PWMGC_B_FLT_PEND] | fault_event;
		cl_p = n.ctrl[`PWMGC_B_CL_PEND] | current_limit_event;
		trg_p = n.ctrl[`PWMGC_B_TRG_PEND] | trigger_event;
		n.ctrl[`PWMGC_B_FLT_PEND] = flt_p & n.ctrl[`PWMGC_B_FLT_IEN];
		n.ctrl[`PWMGC_B_CL_PEND] = cl_p & n.ctrl[`PWMGC_B_CL_IEN];
		n.ctrl[`PWMGC_B_TRG_PEND] = trg_p & n.ctrl[`PWMGC_B_TRG_IEN];
		n.gen_irq = (n.ctrl[`PWMGC_B_FLT_PEND] & n.ctrl[`PWMGC_B_FLT_IEN])
			| (n.ctrl[`PWMGC_B_CL_PEND] & n.ctrl[`PWMGC_B_CL_IEN])
			| (n.ctrl[`PWMGC_B_TRG_PEND] & n.ctrl[`PWMGC_B_TRG_IEN]);
		ev = {boundary & s.mod_en, trigger_event, current_limit_event, fault_event};
		n.status = (s.status & ~rd_clr) | ev; // set wins over the read clear
		n.irq = |(n.status & n.mask);
		// ready flags look at the next state so a held item blocks the next
		n.awready = !n.aw_held && !n.bvalid;
		n.wready = !n.w_held && !n.bvalid;
		n.arready = !n.rvalid;
	end

	// single state register, frozen while ce is low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.mper <= `PWMGC_RST_MPER;
		end else if (ce) begin
			s <= n;
		end
	end

	// outputs straight from the state flops
	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rresp = s.rresp;
	assign s_axi_rdata = s.rdata;
	assign high_output = s.hi;
	assign low_output = s.lo;
	assign generator_irq = s.gen_irq;
	assign irq = s.irq;
endmodule

// ===== pwmgc_cfg.svh
// offsets, field positions, reset values and timing counts of the pwm generator control block
`ifndef PWMGC_CFG_SVH
`define PWMGC_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PWMGC_OFF_CTRL 8'h00
`define PWMGC_OFF_PDUTY 8'h04
`define PWMGC_OFF_MODCTL 8'h08
`define PWMGC_OFF_MPER 8'h0C
`define PWMGC_OFF_MDUTY 8'h10
`define PWMGC_OFF_PHASE 8'h14
`define PWMGC_OFF_SDUTY 8'h18
`define PWMGC_OFF_IRQST 8'h1C
`define PWMGC_OFF_IRQMSK 8'h20
// ----------------------------------------
// generator_control field positions
// ----------------------------------------
`define PWMGC_B_FLT_PEND 15
`define PWMGC_B_CL_PEND 14
`define PWMGC_B_TRG_PEND 13
`define PWMGC_B_FLT_IEN 12
`define PWMGC_B_CL_IEN 11
`define PWMGC_B_TRG_IEN 10
`define PWMGC_B_ITB 9
`define PWMGC_B_MASTER_DUTY_SELECT 8
`define PWMGC_B_DTC_HI 7
`define PWMGC_B_DTC_LO 6
`define PWMGC_B_CAM 2
`define PWMGC_B_EXTERNAL_RESET_CONTROL 1
`define PWMGC_B_IUE 0
`define PWMGC_CTRL_WMASK 16'hFFC7
// module_control field positions
`define PWMGC_B_MOD_EN 15
// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define PWMGC_RST_MPER 16'hFFF8
`define PWMGC_DTC_POS 2'h0
`define PWMGC_DTC_NEG 2'h1
`define PWMGC_DTC_OFF 2'h2
`define PWMGC_OM_CMP 2'h0
`define PWMGC_OM_RED 2'h1
`define PWMGC_OM_PP 2'h2
`define PWMGC_OM_IND 2'h3
`define PWMGC_RESP_OKAY 2'h0
`define PWMGC_RESP_SLVERR 2'h2
// ----------------------------------------
// timing
// ----------------------------------------
`define PWMGC_CLK_MHZ 250
`define PWMGC_EDGE_NS 40
`define PWMGC_EDGE_CYC ((`PWMGC_EDGE_NS * `PWMGC_CLK_MHZ) / 1000)
`define PWMGC_COARSE_STEP 3
`endif

// ===== pwmgc_pkg.sv
// types of the pwm generator control block
package pwmgc_pkg;
	// all state of the top module
	typedef struct packed {
		logic [15:0] ctrl;
		logic [15:0] pduty;
		logic [15:0] sduty;
		logic [15:0] mper;
		logic [15:0] mduty;
		logic [15:0] phase;
		logic [15:0] act_h;
		logic [15:0] act_l;
		logic [15:0] cnt;
		logic dir_down;
		logic pp_sel;
		logic mod_en;
		logic [1:0] omode;
		logic [15:0] dt_cnt;
		logic cmp_prev;
		logic hi;
		logic lo;
		logic gen_irq;
		logic [3:0] status;
		logic [3:0] mask;
		logic irq;
		logic aw_held;
		logic [7:0] awaddr;
		logic w_held;
		logic [15:0] wdata;
		logic [1:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} pwmgc_state_t;
endpackage

// ===== pwmgc_gate_model.sv
// gate driver model: totals the on-time of both gate drives
module pwmgc_gate_model (
	input wire logic aclk,
	input wire logic high_output,
	input wire logic low_output,
	output int unsigned high_cycles,
	output int unsigned low_cycles
);
	timeunit 1ns;
	timeprecision 1ps;
	// running totals; the bench differences them over whole periods so phase does not matter
	always_ff @(posedge aclk) begin
		high_cycles <= high_cycles + 32'(high_output);
		low_cycles <= low_cycles + 32'(low_output);
	end
endmodule

// ===== pwmgc_top_monitor.sv
// assertion checker bound to the pwm generator control top
`include "pwmgc_cfg.svh"
module pwmgc_top_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic fault_event,
	input wire logic current_limit_event,
	input wire logic trigger_event,
	input wire logic generator_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rd_addr_reg;
	logic event_reg;
	// read address in flight and any event one cycle late
	always_ff @(posedge aclk) begin
		if (s_axi_arvalid && s_axi_arready) rd_addr_reg <= s_axi_araddr;
		event_reg <= fault_event || current_limit_event || trigger_event;
	end
	// ----------------------------------------
	// checks; a frozen clock enable cancels them
	// ----------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn || !ce);
	sequence s_write_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_read_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	chk_write_answer: assert property (s_write_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response not two cycles after transfer");
	chk_read_answer: assert property (s_read_taken |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer missing");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	chk_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	chk_ctrl_unused: assert property (s_axi_rvalid && rd_addr_reg == 8'h00 |-> s_axi_rdata[5:3] == 3'h0)
		else $error("unused control bits read nonzero");
	chk_unmapped_read: assert property (s_axi_rvalid && rd_addr_reg > 8'h20 |-> s_axi_rresp == 2'h2)
		else $error("unmapped read not refused");
	chk_irq_cause: assert property ($rose(generator_irq) |-> event_reg || $past(event_reg))
		else $error("generator request rose without event");
endmodule
bind pwmgc_top pwmgc_top_monitor u_monitor (.*);

// ===== pwmgc_top_test.sv
// self-checking bench for the pwm generator control block
`include "pwmgc_cfg.svh"
module pwmgc_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, high_output, low_output, generator_irq, irq;
	logic fault_event, current_limit_event, trigger_event;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [33:0] exp_q[$];
	logic [15:0] rnd;
	int unsigned high_cycles, low_cycles, h0, l0;
	int fail_count, cmp_count, cyc;
	// shapes: control, module control, high and low cycles per 128; the last holds current limit high
	// dead time blanks the comparator change cycle plus eight more, so nine per edge
	logic [15:0] cfg_ctrl[8] = '{16'h0080, 16'h0281, 16'h0181, 16'h0001, 16'h0041, 16'h0081, 16'h0085, 16'h0283};
	logic [15:0] cfg_mode[8] = '{16'h8003, 16'h8003, 16'h8000, 16'h8000, 16'h8000, 16'h8002, 16'h8001, 16'h8003};
	int cfg_high[8] = '{24, 48, 96, 6, 42, 12, 24, 128};
	int cfg_low[8] = '{0, 0, 32, 86, 122, 12, 24, 0};
	pwmgc_top dut (.*);
	pwmgc_gate_model gates (.*);
	// ----------------------------------------
	// bus tasks and comparison
	// ----------------------------------------
	task automatic chk(input logic [33:0] got, input logic [33:0] e);
		cmp_count++;
		if (got !== e) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r = 2'h0);
		logic pa;
		logic pw;
		pa = 1'b1;
		pw = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (pa || pw) begin
			@(posedge aclk);
			if (s_axi_awready) pa = 1'b0;
			if (s_axi_wready) pw = 1'b0;
			s_axi_awvalid <= pa;
			s_axi_wvalid <= pw;
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		chk(34'(s_axi_bresp), 34'(r));
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r = 2'h0);
		exp_q.push_back({r, 16'h0000, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic pulse(input int i);
		{fault_event, current_limit_event, trigger_event} <= 3'h4 >> i;
		@(posedge aclk);
		{fault_event, current_limit_event, trigger_event} <= 3'h0;
		@(posedge aclk);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// watcher: each read answer against the oldest note
	always @(posedge aclk) if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
	// hang guard, well above the roughly two thousand cycles the run needs
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			report_and_stop();
		end
	end
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{fault_event, current_limit_event, trigger_event} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		ce = 1'b1;
		void'($urandom(94));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`PWMGC_OFF_CTRL, 16'h0000);
		rd(`PWMGC_OFF_PDUTY, 16'h0000);
		rd(`PWMGC_OFF_MPER, `PWMGC_RST_MPER);
		$display("reset values done");
		// interrupt raised, masked, cleared by reading
		wr(`PWMGC_OFF_IRQMSK, 16'h0001);
		pulse(0);
		pulse(1);
		chk(34'(irq), 34'h1);
		rd(`PWMGC_OFF_IRQST, 16'h0003);
		@(posedge aclk);
		chk(34'(irq), 34'h0);
		wr(`PWMGC_OFF_IRQMSK, 16'h0000);
		pulse(2);
		chk(34'(irq), 34'h0);
		rd(`PWMGC_OFF_IRQST, 16'h0004);
		rd(8'h40, 16'h0000, `PWMGC_RESP_SLVERR);
		wr(8'h40, 16'hFFFF, `PWMGC_RESP_SLVERR);
		$display("interrupt and decode done");
		rnd = 16'($urandom);
		wr(`PWMGC_OFF_PDUTY, rnd);
		rd(`PWMGC_OFF_PDUTY, rnd);
		wr(`PWMGC_OFF_CTRL, 16'hFFFF);
		rd(`PWMGC_OFF_CTRL, 16'h1FC7);
		$display("register access done");
		// pending set only while enabled; clearing the enable clears it
		for (int i = 0; i < 3; i++) begin
			wr(`PWMGC_OFF_CTRL, 16'h1FC7);
			pulse(i);
			rd(`PWMGC_OFF_CTRL, 16'h1FC7 | (16'h8000 >> i));
			chk(34'(generator_irq), 34'h1);
			wr(`PWMGC_OFF_CTRL, (16'h1FC7 ^ (16'h1000 >> i)) | (16'h8000 >> i));
			pulse(i);
			rd(`PWMGC_OFF_CTRL, 16'h1FC7 ^ (16'h1000 >> i));
			chk(34'(generator_irq), 34'h0);
		end
		$display("pending flags done");
		wr(`PWMGC_OFF_MPER, 16'h003F);
		wr(`PWMGC_OFF_PHASE, 16'h001F);
		wr(`PWMGC_OFF_MDUTY, 16'h0030);
		wr(`PWMGC_OFF_PDUTY, 16'h000C);
		// output shapes for time base, duty source and output mode
		for (int k = 0; k < 8; k++) begin
			wr(`PWMGC_OFF_MODCTL, 16'h0000);
			wr(`PWMGC_OFF_CTRL, cfg_ctrl[k]);
			wr(`PWMGC_OFF_MODCTL, cfg_mode[k]);
			current_limit_event <= (k == 7);
			repeat (80) @(posedge aclk);
			h0 = high_cycles;
			l0 = low_cycles;
			repeat (128) @(posedge aclk);
			chk(34'(high_cycles - h0), 34'(cfg_high[k]));
			chk(34'(low_cycles - l0), 34'(cfg_low[k]));
		end
		current_limit_event <= 1'b0;
		wr(`PWMGC_OFF_MODCTL, 16'h0000);
		repeat (4) @(posedge aclk);
		chk(34'({high_output, low_output}), 34'h0);
		$display("pwm output shapes done");
		// every event and the period boundary have fired since the last status read
		rd(`PWMGC_OFF_IRQST, 16'h000F);
		// a frozen clock enable must swallow the fault event
		ce <= 1'b0;
		pulse(0);
		ce <= 1'b1;
		rd(`PWMGC_OFF_IRQST, 16'h0000);
		$display("clock enable done");
		report_and_stop();
	end
endmodule
